// ---- src/sbt_cfg.svh ----
// register map, field positions, reset values and prescale counts of the interval timer
`ifndef SBT_CFG_SVH
`define SBT_CFG_SVH
`define SBT_ADDR_W 3
`define SBT_DATA_W 16
`define SBT_OFF_CONTROL 3'h0
`define SBT_OFF_COUNT 3'h1
`define SBT_OFF_PERIOD 3'h2
`define SBT_OFF_STATUS 3'h3
`define SBT_OFF_MASK 3'h4
`define SBT_BIT_RUN 15
`define SBT_BIT_IDLE 13
`define SBT_BIT_GATE 6
`define SBT_BIT_PS_HI 5
`define SBT_BIT_PS_LO 4
`define SBT_BIT_SYNC 2
`define SBT_BIT_SRC 1
`define SBT_CONTROL_MASK 16'ha076
`define SBT_CONTROL_RST 16'h0000
`define SBT_COUNT_RST 16'h0000
`define SBT_PERIOD_RST 16'hffff
`define SBT_STATUS_W 2
`define SBT_ST_MATCH 0
`define SBT_ST_GATE_END 1
`define SBT_PS_W 8
`define SBT_PS_TERM_1 8'h00
`define SBT_PS_TERM_8 8'h07
`define SBT_PS_TERM_64 8'h3f
`define SBT_PS_TERM_256 8'hff
`endif

// ---- src/sbt_pkg.sv ----
// types shared by the interval timer
package sbt_pkg;
	typedef enum logic [1:0] {
		SBT_MODE_TIMER,
		SBT_MODE_GATED,
		SBT_MODE_SYNC_COUNT,
		SBT_MODE_ASYNC_COUNT
	} sbt_mode_t;
endpackage : sbt_pkg

// ---- src/sbt_timer.sv ----
// sixteen-bit interval timer with prescaler, gating, counter modes and interrupt
// Overview of operation
// [RQ1] one 16-bit counter serves as free-running interval timer/counter or clock time base.
// [RQ2] the counter can run from the low-power 32 kHz oscillator fed on the external pin.
// [RQ3] asynchronous counter mode counts external edges with no resynchronising stage.
// [RQ4] synchronised counter mode resynchronises the prescaler output, not its input.
// [RQ5] timer and gated timer modes count the instruction clock.
// [RQ6] synchronous and asynchronous counter modes count the external pin.
// [RQ7] source, gate and sync bits choose timer, gated, sync counter or async counter mode.
// [RQ8] control bit 15 starts the timer when 1 and stops it when 0.
// [RQ9] control bit 13 set halts the timer in idle, clear lets it run in idle.
// [RQ10] control bit 6 enables gated accumulation and is ignored with the external source.
// [RQ11] control bits 5-4 pick prescale 1:1, 1:8, 1:64 or 1:256.
// [RQ12] control bit 2 picks synchronised external counting and is ignored on internal clock.
// [RQ13] control bit 1 picks rising edges of the external pin, else the instruction clock.
// [RQ14] unimplemented control bits read zero and implemented ones reset to zero.
// [RQ15] a count at the period value wraps the counter to zero and raises the interrupt flag.
`timescale 1ns/100ps
`include "sbt_cfg.svh"
module sbt_timer import sbt_pkg::*; #(
	parameter int COUNT_W = 16
) (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic [`SBT_ADDR_W-1:0] addr_in,
	input wire logic [`SBT_DATA_W-1:0] wdata_in,
	input wire logic write_in,
	input wire logic read_in,
	output logic [`SBT_DATA_W-1:0] rdata_out,
	input wire logic instruction_clock_en_in,
	input wire logic ext_count_pin_in,
	input wire logic idle_mode_in,
	output logic irq_out,
	output logic [COUNT_W-1:0] count_out
);
	// the register bus carries the whole count in one word
	if (COUNT_W != `SBT_DATA_W) begin : g_width_check
		$error("sbt_timer: COUNT_W must equal the register width");
	end

	logic [`SBT_DATA_W-1:0] timer_one_control;
	logic [COUNT_W-1:0] count;
	logic [COUNT_W-1:0] period;
	logic [`SBT_STATUS_W-1:0] status;
	logic [`SBT_STATUS_W-1:0] mask;
	logic [`SBT_PS_W-1:0] presc_cnt;
	logic pin_q;
	logic sync_a;
	logic sync_b;

	// control fields
	wire logic run_enable = timer_one_control[`SBT_BIT_RUN];
	wire logic halt_when_idle = timer_one_control[`SBT_BIT_IDLE];
	wire logic gated_accumulate = timer_one_control[`SBT_BIT_GATE];
	wire logic [1:0] prescale_select = timer_one_control[`SBT_BIT_PS_HI:`SBT_BIT_PS_LO];
	wire logic ext_clock_sync_select = timer_one_control[`SBT_BIT_SYNC];
	wire logic clock_source_select = timer_one_control[`SBT_BIT_SRC];

	// bus decode
	wire logic wr_control = write_in && (addr_in == `SBT_OFF_CONTROL);
	wire logic wr_count = write_in && (addr_in == `SBT_OFF_COUNT);
	wire logic wr_period = write_in && (addr_in == `SBT_OFF_PERIOD);
	wire logic wr_status = write_in && (addr_in == `SBT_OFF_STATUS);
	wire logic wr_mask = write_in && (addr_in == `SBT_OFF_MASK);

	// mode decode
	sbt_mode_t mode;
	assign mode = !clock_source_select ?
		(gated_accumulate ? SBT_MODE_GATED : SBT_MODE_TIMER) :
		(ext_clock_sync_select ? SBT_MODE_SYNC_COUNT : SBT_MODE_ASYNC_COUNT); // [RQ7]

	// idle halt only when asked to
	wire logic running = run_enable && !(halt_when_idle && idle_mode_in); // [RQ8] [RQ9]

	// the pin doubles as the 32 kHz oscillator input and the gate input
	wire logic ext_rise = ext_count_pin_in && !pin_q; // [RQ2] [RQ13]
	wire logic gate_fall = !ext_count_pin_in && pin_q;

	logic src_tick;
	always_comb begin
		case (mode)
			SBT_MODE_TIMER: src_tick = instruction_clock_en_in; // [RQ5]
			SBT_MODE_GATED: src_tick = instruction_clock_en_in && ext_count_pin_in; // [RQ5] [RQ10]
			SBT_MODE_SYNC_COUNT: src_tick = ext_rise; // [RQ6]
			SBT_MODE_ASYNC_COUNT: src_tick = ext_rise; // [RQ6]
			default: src_tick = 1'b0;
		endcase
	end

	logic [`SBT_PS_W-1:0] presc_term;
	always_comb begin
		case (prescale_select)
			2'h0: presc_term = `SBT_PS_TERM_1; // [RQ11]
			2'h1: presc_term = `SBT_PS_TERM_8; // [RQ11]
			2'h2: presc_term = `SBT_PS_TERM_64; // [RQ11]
			2'h3: presc_term = `SBT_PS_TERM_256; // [RQ11]
			default: presc_term = `SBT_PS_TERM_1;
		endcase
	end

	// >= so a ratio cut while running cannot miss the terminal count
	wire logic presc_tick = running && src_tick && (presc_cnt >= presc_term);
	wire logic [`SBT_PS_W-1:0] next_presc_cnt = (!running || presc_tick) ? `SBT_PS_W'(0) :
		(src_tick ? presc_cnt + `SBT_PS_W'(1) : presc_cnt);

	// sync happens after the prescaler, so a slow crystal edge costs two cycles of latency only
	wire logic sync_mode = (mode == SBT_MODE_SYNC_COUNT);
	wire logic count_tick = running && (sync_mode ? sync_b : presc_tick); // [RQ3] [RQ4] [RQ12]
	wire logic at_period = (count == period);
	wire logic wrap = count_tick && at_period;
	wire logic [COUNT_W-1:0] next_count = wr_count ? wdata_in :
		(wrap ? COUNT_W'(0) : (count_tick ? count + COUNT_W'(1) : count)); // [RQ1] [RQ15]

	// hardware set wins over the write-one clear
	wire logic [`SBT_STATUS_W-1:0] st_set = {gate_fall && running && (mode == SBT_MODE_GATED), wrap};
	wire logic [`SBT_STATUS_W-1:0] st_clr = wr_status ? wdata_in[`SBT_STATUS_W-1:0] : '0;
	wire logic [`SBT_STATUS_W-1:0] next_status = (status & ~st_clr) | st_set; // [RQ15]

	logic [`SBT_DATA_W-1:0] rd_mux;
	always_comb begin
		case (addr_in)
			`SBT_OFF_CONTROL: rd_mux = timer_one_control & `SBT_CONTROL_MASK; // [RQ14]
			`SBT_OFF_COUNT: rd_mux = count;
			`SBT_OFF_PERIOD: rd_mux = period;
			`SBT_OFF_STATUS: rd_mux = {{(`SBT_DATA_W-`SBT_STATUS_W){1'b0}}, status};
			`SBT_OFF_MASK: rd_mux = {{(`SBT_DATA_W-`SBT_STATUS_W){1'b0}}, mask};
			default: rd_mux = '0;
		endcase
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			timer_one_control <= `SBT_CONTROL_RST; // [RQ14]
			period <= `SBT_PERIOD_RST;
			mask <= '0;
		end else begin
			if (wr_control) begin
				timer_one_control <= wdata_in & `SBT_CONTROL_MASK; // [RQ8] [RQ14]
			end
			if (wr_period) begin
				period <= wdata_in;
			end
			if (wr_mask) begin
				mask <= wdata_in[`SBT_STATUS_W-1:0];
			end
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			count <= `SBT_COUNT_RST;
			presc_cnt <= '0;
			status <= '0;
			pin_q <= 1'b0;
		end else begin
			count <= next_count;
			presc_cnt <= next_presc_cnt;
			status <= next_status;
			pin_q <= ext_count_pin_in;
		end
	end

	// two-stage resynchroniser on the prescaler output
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
		end else begin
			sync_a <= presc_tick && sync_mode; // [RQ4]
			sync_b <= sync_a; // [RQ4]
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rdata_out <= '0;
		end else begin
			rdata_out <= read_in ? rd_mux : '0;
		end
	end

	assign irq_out = |(status & mask);
	assign count_out = count;

	// ratio check helper: source ticks seen since the prescaler last restarted
	logic [`SBT_PS_W:0] chk_ps_seen;
	logic chk_ps_fresh;
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			chk_ps_seen <= '0;
			chk_ps_fresh <= 1'b1;
		end else begin
			if (!running || presc_tick) begin
				chk_ps_seen <= '0;
			end else if (src_tick) begin
				chk_ps_seen <= chk_ps_seen + (`SBT_PS_W+1)'(1);
			end
			// a ratio change mid-period voids the count until the next restart
			if (wr_control && running) begin
				chk_ps_fresh <= 1'b0;
			end else if (!running || presc_tick) begin
				chk_ps_fresh <= 1'b1;
			end
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);

	ctrl_read_zero_a: assert property ( // [RQ14]
		read_in && addr_in == `SBT_OFF_CONTROL |=> (rdata_out & ~`SBT_CONTROL_MASK) == '0)
		else $error("reserved control bits read nonzero");
	stop_holds_a: assert property ( // [RQ8]
		!run_enable && !wr_count |=> count == $past(count))
		else $error("count moved while stopped");
	idle_halt_a: assert property ( // [RQ9]
		halt_when_idle && idle_mode_in && !wr_count |=> count == $past(count))
		else $error("count moved in idle with halt set");
	wrap_zero_a: assert property ( // [RQ15]
		count_tick && at_period && !wr_count |=> count == '0)
		else $error("counter did not wrap at period");
	flag_set_a: assert property ( // [RQ15]
		wrap |=> status[`SBT_ST_MATCH])
		else $error("match flag not set");
	irq_follow_a: assert property ( // [RQ15]
		wrap && mask[`SBT_ST_MATCH] && !wr_mask |=> irq_out)
		else $error("masked-in match did not raise interrupt");
	timer_direct_a: assert property ( // [RQ5]
		mode == SBT_MODE_TIMER && running && prescale_select == 2'h0 && instruction_clock_en_in
		|-> count_tick)
		else $error("1:1 timer mode missed an instruction clock");
	ext_gate_ignored_a: assert property ( // [RQ10]
		clock_source_select |-> src_tick == ext_rise)
		else $error("gate bit affected external counting");
	sync_delay_a: assert property ( // [RQ4]
		sync_mode && presc_tick && $stable(timer_one_control) && !idle_mode_in
		|-> ##2 (count_tick || !running))
		else $error("synchronised tick not two cycles after prescaler");
	async_direct_a: assert property ( // [RQ3]
		mode == SBT_MODE_ASYNC_COUNT && presc_tick |-> count_tick)
		else $error("async mode did not count prescaler output at once");
	presc_256_a: assert property ( // [RQ11]
		presc_tick && prescale_select == 2'h3 && $past(src_tick)
		|-> $past(presc_cnt) == 8'hfe || $past(wr_control))
		else $error("1:256 prescaler fired early");

	// datapath, bus and source selection
	presc_ratio_a: assert property ( // [RQ11]
		running && src_tick && chk_ps_fresh |-> presc_tick == (chk_ps_seen == {1'b0, presc_term}))
		else $error("prescaler ratio differs from the selected one");
	count_load_a: assert property ( // [RQ1]
		wr_count |=> count == $past(wdata_in))
		else $error("count write not taken");
	count_step_a: assert property ( // [RQ1]
		count_tick && !at_period && !wr_count |=> count == $past(count) + COUNT_W'(1))
		else $error("count did not step by one");
	count_hold_a: assert property ( // [RQ1]
		!count_tick && !wr_count |=> count == $past(count))
		else $error("count moved without a tick");
	read_count_a: assert property ( // [RQ1]
		read_in && addr_in == `SBT_OFF_COUNT |=> rdata_out == $past(count))
		else $error("count read back wrong");
	rdata_idle_a: assert property ( // [RQ14]
		!read_in |=> rdata_out == '0)
		else $error("read data outside the read cycle");
	ctrl_write_a: assert property ( // [RQ14]
		wr_control |=> timer_one_control == ($past(wdata_in) & `SBT_CONTROL_MASK))
		else $error("control write not taken");
	reserved_zero_a: assert property ( // [RQ14]
		(timer_one_control & ~`SBT_CONTROL_MASK) == '0)
		else $error("reserved control bit held");
	period_load_a: assert property ( // [RQ15]
		wr_period |=> period == $past(wdata_in))
		else $error("period write not taken");
	mask_load_a: assert property ( // [RQ15]
		wr_mask |=> mask == $past(wdata_in[`SBT_STATUS_W-1:0]))
		else $error("mask write not taken");
	status_clear_a: assert property ( // [RQ15]
		wr_status && wdata_in[`SBT_ST_MATCH] && !wrap |=> !status[`SBT_ST_MATCH])
		else $error("match flag not cleared by write one");
	mode_select_a: assert property ( // [RQ7]
		!clock_source_select |-> (mode == SBT_MODE_GATED) == gated_accumulate)
		else $error("internal source mode does not follow the gate bit");
	timer_pin_ignored_a: assert property ( // [RQ5] [RQ13]
		!clock_source_select && !instruction_clock_en_in |-> !count_tick)
		else $error("internal source counted without an instruction tick");
	ext_en_ignored_a: assert property ( // [RQ6] [RQ13]
		mode == SBT_MODE_ASYNC_COUNT && !ext_rise |-> !count_tick)
		else $error("external source counted without a pin edge");
	gated_low_a: assert property ( // [RQ10]
		mode == SBT_MODE_GATED && !ext_count_pin_in |-> !count_tick)
		else $error("gated timer counted with the gate low");
	gate_flag_a: assert property ( // [RQ10]
		mode == SBT_MODE_GATED && running && gate_fall |=> status[`SBT_ST_GATE_END])
		else $error("gate end flag not set");
	sync_no_direct_a: assert property ( // [RQ4] [RQ12]
		sync_mode && !sync_b |-> !count_tick)
		else $error("synchronised mode counted an unsynchronised tick");
	stop_clears_presc_a: assert property ( // [RQ8]
		!running |=> presc_cnt == '0)
		else $error("prescaler kept its count while stopped");

	wrap_seen_c: cover property (wrap);
	gated_end_c: cover property (st_set[`SBT_ST_GATE_END]);
	async_count_c: cover property (mode == SBT_MODE_ASYNC_COUNT && count_tick);
	sync_count_c: cover property (sync_mode && count_tick);
	irq_raise_c: cover property ($rose(irq_out));
endmodule : sbt_timer

// ---- testbench/sbt_ext_source.sv ----
// behavioural external count source: crystal-like square wave on the count pin
`timescale 1ns/100ps
module sbt_ext_source (
	input wire logic clk_in,
	input wire logic run_in,
	input wire logic level_in,
	input wire logic [7:0] half_in,
	output logic pin_out,
	output int edges_out
);
	logic osc = 1'b0;
	logic last = 1'b0;
	logic [7:0] phase = 8'h00;
	int seen = 0;
	assign edges_out = seen;
	// oscillator stands still between runs, the pin then shows the idle level
	assign pin_out = run_in ? osc : level_in;
	always @(posedge clk_in) begin
		last <= pin_out;
		if (pin_out && !last) begin
			seen <= seen + 1;
		end
		if (!run_in) begin
			osc <= 1'b0;
			phase <= 8'h00;
		end else if (phase == half_in - 8'h01) begin
			osc <= ~osc;
			phase <= 8'h00;
		end else begin
			phase <= phase + 8'h01;
		end
	end
endmodule : sbt_ext_source

// ---- testbench/sbt_timer_tb_top.sv ----
// self-checking bench for the interval timer
`timescale 1ns/100ps
module sbt_timer_tb_top;
	logic clk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic en = 1'b0;
	logic idle = 1'b0;
	logic run = 1'b0;
	logic level = 1'b0;
	logic pin;
	logic irq;
	logic [15:0] rdata;
	logic [15:0] cnt;
	int edges, mark, mismatches = 0, tests_run = 0, cycles = 0;
	int res[4] = '{256, 32, 4, 1};
	logic [15:0] ctl_tab[3] = '{16'h8002, 16'h8006, 16'h8042};
	always #12.5 clk_in = ~clk_in;
	sbt_ext_source ext (.clk_in(clk_in), .run_in(run), .level_in(level), .half_in(8'h03),
		.pin_out(pin), .edges_out(edges));
	sbt_timer dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr), .wdata_in(wdata),
		.write_in(wr), .read_in(rd), .rdata_out(rdata), .instruction_clock_en_in(en),
		.ext_count_pin_in(pin), .idle_mode_in(idle), .irq_out(irq), .count_out(cnt));
	task automatic summarize();
		if (mismatches == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : summarize
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	// an edge passes before each strobe, so no strobe is driven twice in one step
	task automatic wreg(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_in);
		wr <= 1'b0;
	endtask : wreg
	task automatic rchk(input string name, input logic [2:0] a, input logic [15:0] exp);
		@(posedge clk_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_in);
		rd <= 1'b0;
		#1 chk(name, exp, rdata);
	endtask : rchk
	task automatic ticks(input int n);
		@(posedge clk_in);
		en <= 1'b1;
		repeat (n) @(posedge clk_in);
		en <= 1'b0;
	endtask : ticks
	task automatic run_from(input logic [15:0] ctl, input int n);
		wreg(3'h1, 16'h0000);
		wreg(3'h0, ctl);
		ticks(n);
		wreg(3'h0, ctl & 16'h7fff);
	endtask : run_from
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			summarize();
		end
	end
	initial begin
		repeat (6) @(posedge clk_in);
		reset_n_in <= 1'b1;
		rchk("control", 3'h0, 16'h0000);
		rchk("count", 3'h1, 16'h0000);
		rchk("period", 3'h2, 16'hffff);
		rchk("status", 3'h3, 16'h0000);
		wreg(3'h5, 16'hffff);
		rchk("unmapped", 3'h5, 16'h0000);
		wreg(3'h0, 16'hffff);
		rchk("control bits", 3'h0, 16'ha076);
		for (int i = 0; i < 4; i++) begin
			run_from(16'h8004 | 16'(i << 4), 256);
			rchk("prescale", 3'h1, 16'(res[i]));
			chk("count out", 16'(res[i]), cnt);
		end
		@(posedge clk_in);
		idle <= 1'b1;
		run_from(16'ha000, 8);
		rchk("idle halt", 3'h1, 16'h0000);
		run_from(16'h8000, 8);
		rchk("idle run", 3'h1, 16'h0008);
		@(posedge clk_in);
		idle <= 1'b0;
		ticks(8);
		rchk("stopped", 3'h1, 16'h0008);
		wreg(3'h4, 16'h0003);
		wreg(3'h1, 16'h0000);
		wreg(3'h0, 16'h8040);
		ticks(5);
		level <= 1'b1;
		ticks(8);
		level <= 1'b0;
		wreg(3'h0, 16'h0040);
		rchk("gated count", 3'h1, 16'h0008);
		rchk("gate status", 3'h3, 16'h0002);
		chk("gate irq", 16'h0001, {15'h0, irq});
		wreg(3'h3, 16'h0003);
		#1 chk("irq clear", 16'h0000, {15'h0, irq});
		// instruction clock held high: only pin edges may count here
		foreach (ctl_tab[i]) begin
			wreg(3'h1, 16'h0000);
			wreg(3'h0, ctl_tab[i]);
			mark = edges;
			en <= 1'b1;
			run <= 1'b1;
			repeat (60) @(posedge clk_in);
			run <= 1'b0;
			repeat (4) @(posedge clk_in);
			en <= 1'b0;
			wreg(3'h0, 16'h0000);
			rchk("pin count", 3'h1, 16'(edges - mark));
		end
		wreg(3'h2, 16'h0003);
		wreg(3'h4, 16'h0001);
		run_from(16'h8000, 4);
		rchk("wrap", 3'h1, 16'h0000);
		rchk("match", 3'h3, 16'h0001);
		chk("match irq", 16'h0001, {15'h0, irq});
		wreg(3'h4, 16'h0000);
		#1 chk("irq masked", 16'h0000, {15'h0, irq});
		wreg(3'h3, 16'h0001);
		rchk("status clear", 3'h3, 16'h0000);
		summarize();
	end
endmodule : sbt_timer_tb_top
